// ### include/qubp_map.svh
// widths and codes of the quad channel host bus port
`ifndef QUBP_MAP_SVH
`define QUBP_MAP_SVH

`define QUBP_ADDR_W 3
`define QUBP_DATA_W 8
`define QUBP_CHAN_W 2
`define QUBP_SEL_W 4

`define QUBP_CHAN_A 2'h0
`define QUBP_CHAN_B 2'h1
`define QUBP_CHAN_C 2'h2
`define QUBP_CHAN_D 2'h3

`define QUBP_MODE_STROBE 1'b1
`define QUBP_MODE_RWLINE 1'b0

`define QUBP_BYTE_RST 8'h00
`define QUBP_ADDR_RST 3'h0
`define QUBP_STROBE_IDLE 1'b1

`endif

// ### include/qubp_pkg.sv
// types shared by the quad channel host bus port
`default_nettype none
`include "qubp_map.svh"

package qubp_pkg;

  typedef logic [`QUBP_ADDR_W-1:0] qubp_addr_t;
  typedef logic [`QUBP_DATA_W-1:0] qubp_byte_t;
  typedef logic [`QUBP_CHAN_W-1:0] qubp_chan_t;
  typedef logic [`QUBP_SEL_W-1:0] qubp_sel_t;

  typedef enum logic [1:0] {
    QUBP_IDLE,
    QUBP_RD_FETCH,
    QUBP_RD_DRIVE,
    QUBP_WR_WAIT
  } qubp_state_t;

endpackage : qubp_pkg

`default_nettype wire

// ### logic/qubp_edge_det.sv
// edge detector for one synchronous, idle-high bus control input
`timescale 1ns/1ps
`default_nettype none
`include "qubp_map.svh"

module qubp_edge_det (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // watched level
  input wire logic level_i,
  // edge pulses
  output logic fall_o,
  output logic rise_o
);

  logic prev_ff;
  logic nxt_prev;

  always_comb begin
    nxt_prev = level_i;
  end

  // idle-high reset so a strobe already low at release counts as a fall
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prev_ff <= `QUBP_STROBE_IDLE;
    end else begin
      prev_ff <= nxt_prev;
    end
  end

  assign fall_o = prev_ff & ~level_i;
  assign rise_o = ~prev_ff & level_i;

endmodule : qubp_edge_det

`default_nettype wire

// ### logic/qubp_bus_port.sv
// host parallel bus port of a four channel serial device
//
// Function
// - three address bits pick channel register
// - mode pin high strobes, low read/write line
// - strobe mode: read strobe fall starts read
// - read byte driven, host latches at rise
// - strobe mode: write strobe fall starts write
// - write strobe rise loads bus byte; line mode: channel A select rise
// - read/write line mode: high read, low write
// - channel A select gates channel A access
// - line mode: channel A select is chip select
// - eight bit two way data bus
// - strobe mode: B, C, D selects gate channels
// - line mode: B, C selects are channel address
`timescale 1ns/1ps
`default_nettype none
`include "qubp_map.svh"

module qubp_bus_port (
  // clock and reset
  input wire logic CORE_CLK_I,
  input wire logic NRST_I,
  // protocol select
  input wire logic MODE_SEL_I,
  // host address and control
  input wire qubp_pkg::qubp_addr_t ADDR_I,
  input wire logic READ_STROBE_N_I,
  input wire logic WRITE_STROBE_N_I,
  input wire logic CHAN_A_SELECT_N_I,
  input wire logic CHAN_B_SELECT_N_I,
  input wire logic CHAN_C_SELECT_N_I,
  input wire logic CHAN_D_SELECT_N_I,
  // host data bus, split into three signals
  input wire qubp_pkg::qubp_byte_t DATA_I,
  output qubp_pkg::qubp_byte_t DATA_O,
  output logic DATA_OE_O,
  // access toward the channel registers
  output logic REG_RD_O,
  output logic REG_WR_O,
  output qubp_pkg::qubp_chan_t REG_CHAN_O,
  output qubp_pkg::qubp_addr_t REG_ADDR_O,
  output qubp_pkg::qubp_byte_t REG_WDATA_O,
  input wire qubp_pkg::qubp_byte_t REG_RDATA_I
);

  import qubp_pkg::*;

  // one-hot-low select lines to a channel number, A wins on overlap
  function automatic qubp_chan_t sel_to_chan(input qubp_sel_t sel_n);
    qubp_chan_t chan;
    chan = `QUBP_CHAN_A;
    if (!sel_n[0]) begin
      chan = `QUBP_CHAN_A;
    end else if (!sel_n[1]) begin
      chan = `QUBP_CHAN_B;
    end else if (!sel_n[2]) begin
      chan = `QUBP_CHAN_C;
    end else if (!sel_n[3]) begin
      chan = `QUBP_CHAN_D;
    end
    return chan;
  endfunction : sel_to_chan

  function automatic logic any_sel(input qubp_sel_t sel_n);
    return ~&sel_n;
  endfunction : any_sel

  qubp_state_t state_ff;
  qubp_state_t nxt_state;
  logic mode_ff;
  logic nxt_mode;
  logic rd_ff;
  logic nxt_rd;
  logic wr_ff;
  logic nxt_wr;
  qubp_chan_t chan_ff;
  qubp_chan_t nxt_chan;
  qubp_addr_t addr_ff;
  qubp_addr_t nxt_addr;
  qubp_byte_t wdata_ff;
  qubp_byte_t nxt_wdata;
  qubp_byte_t rdata_ff;
  qubp_byte_t nxt_rdata;

  qubp_sel_t sel_n;
  logic strobe_mode;
  logic cs_on;
  qubp_chan_t cur_chan;
  logic rd_active;
  logic rd_fall;
  logic wr_fall;
  logic wr_rise;
  logic cs_fall;
  logic cs_rise;

  assign sel_n = {CHAN_D_SELECT_N_I, CHAN_C_SELECT_N_I,
                  CHAN_B_SELECT_N_I, CHAN_A_SELECT_N_I};
  assign strobe_mode = (MODE_SEL_I == `QUBP_MODE_STROBE);

  qubp_edge_det u_rd_edge (
    .clk_i(CORE_CLK_I),
    .rst_n_i(NRST_I),
    .level_i(READ_STROBE_N_I),
    .fall_o(rd_fall),
    .rise_o()
  );

  qubp_edge_det u_wr_edge (
    .clk_i(CORE_CLK_I),
    .rst_n_i(NRST_I),
    .level_i(WRITE_STROBE_N_I),
    .fall_o(wr_fall),
    .rise_o(wr_rise)
  );

  qubp_edge_det u_cs_edge (
    .clk_i(CORE_CLK_I),
    .rst_n_i(NRST_I),
    .level_i(CHAN_A_SELECT_N_I),
    .fall_o(cs_fall),
    .rise_o(cs_rise)
  );

  // current chip select and channel, per protocol
  always_comb begin
    if (strobe_mode) begin
      cs_on = any_sel(sel_n);
      cur_chan = sel_to_chan(sel_n);
    end else begin
      cs_on = ~CHAN_A_SELECT_N_I;
      cur_chan = {CHAN_C_SELECT_N_I, CHAN_B_SELECT_N_I};
    end
  end

  // read strobe has no meaning in line mode
  always_comb begin
    if (strobe_mode) begin
      rd_active = cs_on & ~READ_STROBE_N_I;
    end else begin
      rd_active = cs_on & WRITE_STROBE_N_I;
    end
  end

  always_comb begin
    nxt_state = state_ff;
    nxt_mode = MODE_SEL_I;
    nxt_rd = 1'b0;
    nxt_wr = 1'b0;
    nxt_chan = chan_ff;
    nxt_addr = addr_ff;
    nxt_wdata = wdata_ff;
    nxt_rdata = rdata_ff;
    // a mode flip mid transfer drops it rather than mixing protocols
    if ((state_ff != QUBP_IDLE) && (mode_ff != MODE_SEL_I)) begin
      nxt_state = QUBP_IDLE;
    end else begin
      case (state_ff)
        QUBP_IDLE: begin
          if (strobe_mode) begin
            if (rd_fall && cs_on) begin
              nxt_chan = cur_chan;
              nxt_addr = ADDR_I;
              nxt_rd = 1'b1;
              nxt_state = QUBP_RD_FETCH;
            end else if (wr_fall && cs_on) begin
              nxt_chan = cur_chan;
              nxt_addr = ADDR_I;
              nxt_state = QUBP_WR_WAIT;
            end
          end else if (cs_fall) begin
            nxt_chan = cur_chan;
            nxt_addr = ADDR_I;
            if (WRITE_STROBE_N_I) begin
              nxt_rd = 1'b1;
              nxt_state = QUBP_RD_FETCH;
            end else begin
              nxt_state = QUBP_WR_WAIT;
            end
          end
        end
        QUBP_RD_FETCH: begin
          // channel answers in the cycle the read pulse is high
          nxt_rdata = REG_RDATA_I;
          nxt_state = QUBP_RD_DRIVE;
        end
        QUBP_RD_DRIVE: begin
          if (!rd_active) begin
            nxt_state = QUBP_IDLE;
          end
        end
        QUBP_WR_WAIT: begin
          if (strobe_mode ? wr_rise : cs_rise) begin
            nxt_wdata = DATA_I;
            nxt_wr = 1'b1;
            nxt_state = QUBP_IDLE;
          end
        end
        default: begin
          nxt_state = QUBP_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      state_ff <= QUBP_IDLE;
      mode_ff <= `QUBP_MODE_STROBE;
      rd_ff <= 1'b0;
      wr_ff <= 1'b0;
      chan_ff <= `QUBP_CHAN_A;
      addr_ff <= `QUBP_ADDR_RST;
      wdata_ff <= `QUBP_BYTE_RST;
      rdata_ff <= `QUBP_BYTE_RST;
    end else begin
      state_ff <= nxt_state;
      mode_ff <= nxt_mode;
      rd_ff <= nxt_rd;
      wr_ff <= nxt_wr;
      chan_ff <= nxt_chan;
      addr_ff <= nxt_addr;
      wdata_ff <= nxt_wdata;
      rdata_ff <= nxt_rdata;
    end
  end

  // enable follows the live strobe and select so release is immediate
  assign DATA_OE_O = (state_ff == QUBP_RD_DRIVE) & rd_active;
  assign DATA_O = rdata_ff;

  assign REG_RD_O = rd_ff;
  assign REG_WR_O = wr_ff;
  assign REG_CHAN_O = chan_ff;
  assign REG_ADDR_O = addr_ff;
  assign REG_WDATA_O = wdata_ff;

endmodule : qubp_bus_port

`default_nettype wire

// ### bench/qubp_bus_port_chk.sv
// assertions on the host bus port pins
`timescale 1ns/1ps
`default_nettype none
module qubp_bus_port_chk (
  // clock, reset, mode
  input wire logic CORE_CLK_I,
  input wire logic NRST_I,
  input wire logic MODE_SEL_I,
  // host side
  input wire qubp_pkg::qubp_addr_t ADDR_I,
  input wire logic READ_STROBE_N_I,
  input wire logic WRITE_STROBE_N_I,
  input wire logic CHAN_A_SELECT_N_I,
  input wire logic CHAN_B_SELECT_N_I,
  input wire logic CHAN_C_SELECT_N_I,
  input wire qubp_pkg::qubp_byte_t DATA_I,
  input wire qubp_pkg::qubp_byte_t DATA_O,
  input wire logic DATA_OE_O,
  // register side
  input wire logic REG_RD_O,
  input wire logic REG_WR_O,
  input wire qubp_pkg::qubp_chan_t REG_CHAN_O,
  input wire qubp_pkg::qubp_addr_t REG_ADDR_O,
  input wire qubp_pkg::qubp_byte_t REG_WDATA_O,
  input wire qubp_pkg::qubp_byte_t REG_RDATA_I
);
  import qubp_pkg::*;
  default clocking @(posedge CORE_CLK_I); endclocking
  default disable iff (!NRST_I);
  // commit edge: low two edges back, high one edge back
  sequence wr_rise_s;
    !$past(WRITE_STROBE_N_I, 2) && $past(WRITE_STROBE_N_I);
  endsequence
  sequence cs_rise_s;
    !$past(CHAN_A_SELECT_N_I, 2) && $past(CHAN_A_SELECT_N_I);
  endsequence
  rd_cause_a: assert property (REG_RD_O && $past(MODE_SEL_I) |->
    !$past(READ_STROBE_N_I)) else $error("read pulse without strobe");
  rd_single_a: assert property (REG_RD_O |=> !REG_RD_O)
    else $error("read pulse too long");
  rd_addr_a: assert property (REG_RD_O |-> REG_ADDR_O == $past(ADDR_I))
    else $error("read address wrong");
  oe_data_a: assert property ($rose(DATA_OE_O) |-> $past(REG_RD_O) &&
    DATA_O == $past(REG_RDATA_I)) else $error("driven byte wrong");
  oe_strobe_a: assert property (DATA_OE_O && MODE_SEL_I |->
    !READ_STROBE_N_I) else $error("bus driven outside read");
  oe_line_a: assert property (DATA_OE_O && !MODE_SEL_I |->
    !CHAN_A_SELECT_N_I && WRITE_STROBE_N_I) else $error("line drive");
  wr_strobe_a: assert property (REG_WR_O && $past(MODE_SEL_I) |->
    wr_rise_s ##0 REG_WDATA_O == $past(DATA_I)) else $error("write");
  wr_line_a: assert property (REG_WR_O && !$past(MODE_SEL_I) |->
    cs_rise_s) else $error("line write without select rise");
  chan_a_a: assert property (REG_RD_O && $past(MODE_SEL_I) &&
    !$past(CHAN_A_SELECT_N_I) |-> REG_CHAN_O == 2'h0) else $error("chan");
  chan_line_a: assert property (REG_RD_O && !$past(MODE_SEL_I) |->
    REG_CHAN_O == {$past(CHAN_C_SELECT_N_I), $past(CHAN_B_SELECT_N_I)})
    else $error("line channel wrong");
endmodule : qubp_bus_port_chk
bind qubp_bus_port qubp_bus_port_chk chk (.CORE_CLK_I, .NRST_I,
  .MODE_SEL_I, .ADDR_I, .READ_STROBE_N_I, .WRITE_STROBE_N_I,
  .CHAN_A_SELECT_N_I, .CHAN_B_SELECT_N_I, .CHAN_C_SELECT_N_I, .DATA_I,
  .DATA_O, .DATA_OE_O, .REG_RD_O, .REG_WR_O, .REG_CHAN_O, .REG_ADDR_O,
  .REG_WDATA_O, .REG_RDATA_I);
`default_nettype wire

// ### bench/qubp_reg_model.sv
// channel register bank behind the port
`timescale 1ns/1ps
`default_nettype none
module qubp_reg_model (
  input wire logic clk_i,
  input wire logic wr_i,
  input wire qubp_pkg::qubp_chan_t chan_i,
  input wire qubp_pkg::qubp_addr_t addr_i,
  input wire qubp_pkg::qubp_byte_t wdata_i,
  output qubp_pkg::qubp_byte_t rdata_o
);
  import qubp_pkg::*;
  qubp_byte_t mem [32];
  // unwritten places read unknown, so a stray read shows
  assign rdata_o = mem[{chan_i, addr_i}];
  always @(posedge clk_i) if (wr_i) mem[{chan_i, addr_i}] <= wdata_i;
endmodule : qubp_reg_model
`default_nettype wire

// ### bench/qubp_bus_port_tb_top.sv
// self-checking bench of the host bus port
`timescale 1ns/1ps
`default_nettype none
module qubp_bus_port_tb_top;
  import qubp_pkg::*;
  logic clk, nrst, mode, rd_n, wr_n, oe, rrd, rwr;
  logic [3:0] sel_n;
  qubp_addr_t addr, raddr;
  qubp_byte_t din, dout, rdat, wdat;
  qubp_chan_t rch;
  int mismatches = 0;
  int checks_done = 0;
  qubp_bus_port dut (.CORE_CLK_I(clk), .NRST_I(nrst), .MODE_SEL_I(mode),
    .ADDR_I(addr), .READ_STROBE_N_I(rd_n), .WRITE_STROBE_N_I(wr_n),
    .CHAN_A_SELECT_N_I(sel_n[0]), .CHAN_B_SELECT_N_I(sel_n[1]),
    .CHAN_C_SELECT_N_I(sel_n[2]), .CHAN_D_SELECT_N_I(sel_n[3]),
    .DATA_I(din), .DATA_O(dout), .DATA_OE_O(oe), .REG_RD_O(rrd),
    .REG_WR_O(rwr), .REG_CHAN_O(rch), .REG_ADDR_O(raddr),
    .REG_WDATA_O(wdat), .REG_RDATA_I(rdat));
  qubp_reg_model bank (.clk_i(clk), .wr_i(rwr), .chan_i(rch),
    .addr_i(raddr), .wdata_i(wdat), .rdata_o(rdat));
  initial begin
    clk = 0;
    forever #2 clk = ~clk;
  end
  task automatic cmp(input logic [8:0] got, input logic [8:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp
  // one transfer; ch 4 in strobe mode leaves every select high
  task automatic xf(input logic m, input logic rd, input int ch,
                    input qubp_addr_t a, input qubp_byte_t d);
    @(negedge clk);
    {mode, addr, din} = {m, a, d};
    if (m) begin
      sel_n = ~(4'h1 << ch);
      {rd_n, wr_n} = {!rd, rd};
    end else begin
      rd_n = 1'b1;
      {wr_n, sel_n} = {rd, 1'b1, 2'(ch), 1'b0};
    end
    repeat (4) @(negedge clk);
    if (rd) cmp({oe, oe ? dout : d}, {ch < 4 || !m, d});
    if (m) {rd_n, wr_n} = 2'b11;
    else sel_n[0] = 1'b1;
    @(negedge clk);
    {rd_n, wr_n, sel_n} = 6'h3F;
    @(negedge clk);
    cmp({oe, 8'h00}, 9'h000);
  endtask : xf
  task automatic strobe_test;
    for (int c = 0; c < 4; c++) xf(1, 0, c, 3'(c + 3), 8'hA0 + 8'(c));
    for (int c = 0; c < 4; c++) xf(1, 1, c, 3'(c + 3), 8'hA0 + 8'(c));
    xf(1, 1, 4, 3'h3, 8'hA0);
    $display("strobe mode test done");
  endtask : strobe_test
  task automatic line_test;
    for (int c = 0; c < 4; c++) xf(0, 1, c, 3'(c + 3), 8'hA0 + 8'(c));
    for (int c = 0; c < 4; c++) xf(0, 0, c, 3'(7 - c), 8'hC0 + 8'(c));
    for (int c = 0; c < 4; c++) xf(0, 1, c, 3'(7 - c), 8'hC0 + 8'(c));
    xf(1, 1, 2, 3'h5, 8'hC2);
    $display("line mode test done");
  endtask : line_test
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : end_of_test
  initial begin
    #4000;
    mismatches++;
    end_of_test;
  end
  initial begin
    // reset low, strobe mode, every strobe and select idle high
    {nrst, mode, rd_n, wr_n} = 4'h7;
    sel_n = 4'hF;
    addr = 3'h0;
    din = 8'h00;
    repeat (2) @(negedge clk);
    nrst = 1;
    strobe_test;
    line_test;
    end_of_test;
  end
endmodule : qubp_bus_port_tb_top
`default_nettype wire
